// ==== rtl/aco_color_out.sv ====
// Attribute color output: host attribute registers and the pixel color path.
// Assumes synchronous I/O strobes and pixel inputs on clk_sys at 25 MHz.
`timescale 1ns/100ps
`default_nettype none
module aco_color_out (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic mono_emulation,
  input wire logic pix_valid,
  input wire logic [7:0] pix_attr,
  input wire logic [7:0] char_code,
  input wire logic underline_row,
  input wire logic char_last_col,
  input wire logic nine_dot,
  input wire logic [4:0] scan_row,
  input wire logic [4:0] cursor_start_reg,
  input wire logic [4:0] cursor_end_reg,
  input wire logic cursor_here,
  input wire logic row_start,
  input wire logic line_compare_hit,
  input wire logic vsync,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [1:0] write_mode,
  input wire logic [31:0] mem_rdata,
  output logic [31:0] mem_wdata,
  output logic [31:0] cpu_latch,
  output logic [3:0] pan_out,
  output logic [7:0] charmap_active,
  output logic cursor_on,
  output logic underline_on,
  output logic color_valid,
  input wire logic color_ready,
  output logic [7:0] color_out,
  output logic [7:0] misc_output
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  aco_pkg::aco_toggle_e toggle;
  logic [4:0] index;
  logic [7:0] palette [16];
  logic [7:0] mode_control;
  logic [7:0] color_set_select;
  logic [7:0] panning;
  logic [7:0] charmap_pending;
  logic pan_forced_zero;
  logic [7:0] next_color;
  aco_stream_if stream ();

  // ----------------------------------------
  // Host decode
  // ----------------------------------------
  wire status_port = (io_addr == (mono_emulation ? aco_pkg::PORT_STATUS_MONO
                                                 : aco_pkg::PORT_STATUS_COLOR));
  wire attr_wr = io_wr && (io_addr == aco_pkg::PORT_ATTR_WRITE);
  wire attr_rd = io_rd && (io_addr == aco_pkg::PORT_ATTR_READ);
  wire index_wr = attr_wr && (toggle == aco_pkg::ACO_FF_INDEX);
  wire data_wr = attr_wr && (toggle == aco_pkg::ACO_FF_DATA);
  wire pal_sel = (index <= aco_pkg::IDX_PALETTE_LAST);
  wire wide_pixel = mode_control[aco_pkg::MODE_WIDE_PIXEL_BIT];
  wire pal_select = mode_control[aco_pkg::MODE_SELECT_BIT];
  wire [7:0] pal_entry = palette[pix_attr[3:0]];

  function automatic logic [7:0] attr_read(input logic [4:0] idx);
    if (idx <= aco_pkg::IDX_PALETTE_LAST) attr_read = palette[idx[3:0]];
    else case (idx)
      aco_pkg::IDX_MODE_CONTROL: attr_read = mode_control;
      aco_pkg::IDX_PANNING: attr_read = panning;
      aco_pkg::IDX_COLOR_SET_SELECT: attr_read = color_set_select;
      default: attr_read = 8'h00;
    endcase
  endfunction : attr_read

  // ----------------------------------------
  // Index toggle and data registers
  // ----------------------------------------
  // status read resets toggle
  always_ff @(posedge clk_sys) begin
    if (rst) toggle <= aco_pkg::ACO_FF_INDEX;
    else if (io_rd && status_port) toggle <= aco_pkg::ACO_FF_INDEX;
    else if (attr_wr) toggle <= (toggle == aco_pkg::ACO_FF_INDEX) ? aco_pkg::ACO_FF_DATA
                                                             : aco_pkg::ACO_FF_INDEX;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) index <= 5'h00;
    else if (index_wr) index <= io_wdata[4:0];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      color_set_select <= aco_pkg::RST_COLOR_SET;
      mode_control <= aco_pkg::RST_MODE_CONTROL;
      panning <= aco_pkg::RST_PANNING;
    end else if (data_wr) begin
      case (index)
        aco_pkg::IDX_COLOR_SET_SELECT: color_set_select <= io_wdata & aco_pkg::COLOR_SET_MASK;
        aco_pkg::IDX_MODE_CONTROL: mode_control <= io_wdata & aco_pkg::MODE_CONTROL_MASK;
        aco_pkg::IDX_PANNING: panning <= io_wdata & aco_pkg::PANNING_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) palette[i] <= aco_pkg::RST_PALETTE;
    end else if (data_wr && pal_sel) begin
      palette[index[3:0]] <= io_wdata & aco_pkg::PALETTE_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) io_rdata <= 8'h00;
    else if (attr_rd) io_rdata <= attr_read(index);
    else if (io_rd && io_addr == aco_pkg::PORT_MISC_READ) io_rdata <= misc_output;
    else if (io_rd) io_rdata <= aco_pkg::UNMAPPED_READ;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) misc_output <= 8'h00;
    else if (io_wr && io_addr == aco_pkg::PORT_MISC_OUTPUT) misc_output <= io_wdata;
  end

  // ----------------------------------------
  // Character map, panning, cursor, underline
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) charmap_pending <= aco_pkg::RST_CHARMAP;
    else if (io_wr && io_addr == aco_pkg::PORT_CHARMAP_WRITE) charmap_pending <= io_wdata;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) charmap_active <= aco_pkg::RST_CHARMAP;
    else if (row_start) charmap_active <= charmap_pending;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) pan_forced_zero <= 1'b0;
    else if (vsync) pan_forced_zero <= 1'b0;
    else if (line_compare_hit && mode_control[aco_pkg::MODE_PAN_COMPAT_BIT])
      pan_forced_zero <= 1'b1;
  end

  // Vertical sync restores the programmed value at once
  wire pan_zero_now = (pan_forced_zero || line_compare_hit) && !vsync &&
                      mode_control[aco_pkg::MODE_PAN_COMPAT_BIT];
  always_ff @(posedge clk_sys) begin
    if (rst) pan_out <= 4'h0;
    else pan_out <= pan_zero_now ? 4'h0 : panning[3:0];
  end

  wire cursor_row = (cursor_start_reg <= cursor_end_reg) &&
                    (scan_row >= cursor_start_reg) && (scan_row <= cursor_end_reg);
  always_ff @(posedge clk_sys) begin
    if (rst) cursor_on <= 1'b0;
    else cursor_on <= cursor_here && cursor_row;
  end

  wire line_gfx = (char_code >= aco_pkg::LINE_GFX_FIRST) && (char_code <= aco_pkg::LINE_GFX_LAST);
  wire gap_dot = nine_dot && char_last_col && !line_gfx;
  always_ff @(posedge clk_sys) begin
    if (rst) underline_on <= 1'b0;
    else underline_on <= underline_row && !gap_dot;
  end

  // ----------------------------------------
  // Processor latches
  // ----------------------------------------
  // load four map bytes
  always_ff @(posedge clk_sys) begin
    if (rst) cpu_latch <= 32'h0000_0000;
    else if (mem_rd) cpu_latch <= mem_rdata;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) mem_wdata <= 32'h0000_0000;
    else if (mem_wr && write_mode == 2'h1) mem_wdata <= cpu_latch;
  end

  // ----------------------------------------
  // Color formation
  // ----------------------------------------
  // 256-color bypass
  assign next_color = wide_pixel ? pix_attr :
                      pal_select ? {color_set_select[3:0], pal_entry[3:0]} :
                                   {color_set_select[3:2], pal_entry[5:0]};
  assign stream.valid = pix_valid;
  assign stream.data = next_color;

  aco_skid_buf u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_s(stream.dst),
    .out_valid(color_valid),
    .out_ready(color_ready),
    .out_data(color_out)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_csel_write;
    index_wr && io_wdata[4:0] == aco_pkg::IDX_COLOR_SET_SELECT
    ##[1:2] data_wr && index == aco_pkg::IDX_COLOR_SET_SELECT;
  endsequence
  a_csel_write_mask: assert property (@(posedge clk_sys) disable iff (rst)
    s_csel_write |=> color_set_select == ($past(io_wdata) & aco_pkg::COLOR_SET_MASK))
    else $error("color-set write not stored masked");
  a_csel_read_back: assert property (@(posedge clk_sys) disable iff (rst)
    attr_rd && index == aco_pkg::IDX_COLOR_SET_SELECT |=> io_rdata[7:4] == 4'h0
    && io_rdata[3:0] == color_set_select[3:0]) else $error("color-set readback wrong");
  a_bypass_wide: assert property (@(posedge clk_sys) disable iff (rst)
    wide_pixel |-> next_color == pix_attr) else $error("256-color bypass broken");
  a_top_bits: assert property (@(posedge clk_sys) disable iff (rst)
    !wide_pixel |-> next_color[7:6] == color_set_select[3:2]) else $error("top bits wrong");
  a_select_zero: assert property (@(posedge clk_sys) disable iff (rst)
    !wide_pixel && !pal_select |-> next_color[5:0] == pal_entry[5:0])
    else $error("six palette bits wrong");
  a_select_one: assert property (@(posedge clk_sys) disable iff (rst)
    !wide_pixel && pal_select |-> next_color[5:4] == color_set_select[1:0]
    && next_color[3:0] == pal_entry[3:0]) else $error("four-bit merge wrong");
  a_pan_zeroed: assert property (@(posedge clk_sys) disable iff (rst)
    line_compare_hit && !vsync && mode_control[aco_pkg::MODE_PAN_COMPAT_BIT]
    ##1 !vsync[*2] |-> pan_out == 4'h0) else $error("panning not held at zero");
  a_charmap_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !row_start |=> $stable(charmap_active)) else $error("map changed mid row");
  a_no_split_cursor: assert property (@(posedge clk_sys) disable iff (rst)
    cursor_start_reg > cursor_end_reg |=> !cursor_on) else $error("split cursor shown");
  a_latch_load: assert property (@(posedge clk_sys) disable iff (rst)
    mem_rd |=> cpu_latch == $past(mem_rdata)) else $error("latch not loaded");
  a_mode1_write: assert property (@(posedge clk_sys) disable iff (rst)
    mem_wr && write_mode == 2'h1 |=> mem_wdata == $past(cpu_latch))
    else $error("write mode 1 data wrong");
  a_underline_gap: assert property (@(posedge clk_sys) disable iff (rst)
    underline_row && nine_dot && char_last_col && line_gfx |=> underline_on)
    else $error("line graphics underline broken");
endmodule : aco_color_out
`default_nettype wire

// ==== rtl/aco_pkg.sv ====
// Package for the attribute color output block: I/O port numbers, indices,
// field positions, reset values and enumerations.
// Assumes an 8-bit processor I/O port bus synchronous to clk_sys.
package aco_pkg;
  // ----------------------------------------
  // Host port numbers
  // ----------------------------------------
  localparam logic [15:0] PORT_ATTR_WRITE = 16'h03c0;
  localparam logic [15:0] PORT_ATTR_READ = 16'h03c1;
  localparam logic [15:0] PORT_STATUS_MONO = 16'h03ba;
  localparam logic [15:0] PORT_STATUS_COLOR = 16'h03da;
  localparam logic [15:0] PORT_MISC_OUTPUT = 16'h03c2;
  localparam logic [15:0] PORT_MISC_READ = 16'h03cc;
  localparam logic [15:0] PORT_CHARMAP_WRITE = 16'h03c6;
  // ----------------------------------------
  // Attribute indices
  // ----------------------------------------
  localparam logic [4:0] IDX_PALETTE_LAST = 5'h0f;
  localparam logic [4:0] IDX_MODE_CONTROL = 5'h10;
  localparam logic [4:0] IDX_OVERSCAN = 5'h11;
  localparam logic [4:0] IDX_PLANE_ENABLE = 5'h12;
  localparam logic [4:0] IDX_PANNING = 5'h13;
  localparam logic [4:0] IDX_COLOR_SET_SELECT = 5'h14;
  // ----------------------------------------
  // Field positions and masks
  // ----------------------------------------
  localparam int MODE_SELECT_BIT = 7;
  localparam int MODE_WIDE_PIXEL_BIT = 6;
  localparam int MODE_PAN_COMPAT_BIT = 5;
  localparam int MODE_LINE_GRAPHICS_BIT = 2;
  localparam logic [7:0] MODE_CONTROL_MASK = 8'hef;
  localparam logic [7:0] COLOR_SET_MASK = 8'h0f;
  localparam logic [7:0] PANNING_MASK = 8'h0f;
  localparam logic [7:0] PALETTE_MASK = 8'h3f;
  localparam logic [7:0] LINE_GFX_FIRST = 8'hc0;
  localparam logic [7:0] LINE_GFX_LAST = 8'hdf;
  // ----------------------------------------
  // Reset values and the unmapped read value
  // ----------------------------------------
  localparam logic [7:0] RST_COLOR_SET = 8'h00;
  localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_PANNING = 8'h00;
  localparam logic [7:0] RST_CHARMAP = 8'h00;
  localparam logic [7:0] RST_PALETTE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;
  // ----------------------------------------
  // Buffer and state encodings
  // ----------------------------------------
  localparam int BUF_DEPTH = 2;
  typedef enum logic [0:0] {
    ACO_FF_INDEX = 1'b0,
    ACO_FF_DATA = 1'b1
  } aco_toggle_e;
endpackage : aco_pkg

// ==== rtl/aco_skid_buf.sv ====
// Two-entry buffer for color words, valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module aco_skid_buf (
  input wire logic clk_sys,
  input wire logic rst,
  aco_stream_if.dst in_s,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);
  // Head slot is the output itself, so valid and data leave straight from flops
  logic [7:0] spare_data;
  logic spare_valid;
  wire push = in_s.valid && in_s.ready;
  wire pop = out_valid && out_ready;
  wire head_free = !out_valid || pop;
  // Ready is honest: it drops only when both slots hold words
  assign in_s.ready = !spare_valid;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
    end else if (head_free) begin
      out_valid <= spare_valid || push;
      if (spare_valid) out_data <= spare_data;
      else if (push) out_data <= in_s.data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      spare_valid <= 1'b0;
      spare_data <= 8'h00;
    end else if (head_free) begin
      spare_valid <= 1'b0;
    end else if (push) begin
      spare_valid <= 1'b1;
      spare_data <= in_s.data;
    end
  end
  a_buf_no_overflow: assert property (@(posedge clk_sys) disable iff (rst)
    spare_valid |-> out_valid && !in_s.ready) else $error("buffer slot order broken");
endmodule : aco_skid_buf
`default_nettype wire

// ==== rtl/aco_stream_if.sv ====
// Valid/ready carrier for 8-bit color words between the path and the buffer.
// Assumes both ends share clk_sys.
`timescale 1ns/100ps
`default_nettype none
interface aco_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : aco_stream_if
`default_nettype wire

// ==== tb/aco_dac_model.sv ====
// Behavioural stand-in for the color look-up input of the video DAC.
// Assumes the color stream of aco_color_out on the same clk_sys.
`timescale 1ns/100ps
`default_nettype none
module aco_dac_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic stall,
  input wire logic color_valid,
  input wire logic [7:0] color_out,
  output logic color_ready,
  output logic [7:0] last_word,
  output logic [7:0] prev_word,
  output int rx_count
);
  // ----------------------------------------
  // Word capture
  // ----------------------------------------
  // full byte used as table address
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      color_ready <= 1'b0;
      last_word <= 8'h00;
      prev_word <= 8'h00;
      rx_count <= 0;
    end else begin
      // Ready only changes after an edge, so a stall never tears a word
      color_ready <= !stall;
      if (color_valid && color_ready) begin
        prev_word <= last_word;
        last_word <= color_out;
        rx_count <= rx_count + 1;
      end
    end
  end
endmodule : aco_dac_model
`default_nettype wire

// ==== tb/attribute_color_output_tb.sv ====
// Self-checking bench for aco_color_out with a DAC model on the color stream.
// Assumes inputs change at the falling edge of clk_sys.
`timescale 1ns/100ps
`default_nettype none
module attribute_color_output_tb;
  logic clk_sys = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00, pix_attr = 8'h00, char_code = 8'h00, io_rdata, rd;
  logic mono_emulation = 1'b0, pix_valid = 1'b0, underline_row = 1'b0;
  logic char_last_col = 1'b0, nine_dot = 1'b0, cursor_here = 1'b0, row_start = 1'b0;
  logic line_compare_hit = 1'b0, vsync = 1'b0, mem_rd = 1'b0, mem_wr = 1'b0;
  logic [4:0] scan_row = 5'h00, cursor_start_reg = 5'h00, cursor_end_reg = 5'h00;
  logic [1:0] write_mode = 2'h0;
  logic [31:0] mem_rdata = 32'h00000000, mem_wdata, cpu_latch;
  logic [3:0] pan_out;
  logic [7:0] charmap_active, color_out, misc_output, last_word, prev_word;
  logic cursor_on, underline_on, color_valid, color_ready, stall = 1'b0;
  int rx_count, num_errors = 0, n_tests = 0, cycles = 0;

  always #20 clk_sys = ~clk_sys;

  aco_color_out uut (.clk_sys(clk_sys), .rst(rst), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .mono_emulation(mono_emulation), .pix_valid(pix_valid), .pix_attr(pix_attr),
    .char_code(char_code), .underline_row(underline_row), .char_last_col(char_last_col),
    .nine_dot(nine_dot), .scan_row(scan_row), .cursor_start_reg(cursor_start_reg),
    .cursor_end_reg(cursor_end_reg), .cursor_here(cursor_here), .row_start(row_start),
    .line_compare_hit(line_compare_hit), .vsync(vsync), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .write_mode(write_mode), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata),
    .cpu_latch(cpu_latch), .pan_out(pan_out), .charmap_active(charmap_active),
    .cursor_on(cursor_on), .underline_on(underline_on), .color_valid(color_valid),
    .color_ready(color_ready), .color_out(color_out), .misc_output(misc_output));

  aco_dac_model dac (.clk_sys(clk_sys), .rst(rst), .stall(stall),
    .color_valid(color_valid), .color_out(color_out), .color_ready(color_ready),
    .last_word(last_word), .prev_word(prev_word), .rx_count(rx_count));

  // ----------------------------------------
  // Report and host access tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32

  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk_sys);
    io_wr = 1'b0;
    @(negedge clk_sys);
  endtask : io_write

  task automatic io_read(input logic [15:0] a, output logic [7:0] d);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk_sys);
    io_rd = 1'b0;
    @(negedge clk_sys);
    d = io_rdata;
  endtask : io_read

  // toggle reset before each index write
  task automatic attr_write(input logic [7:0] idx, input logic [7:0] d);
    io_read(16'h03da, rd);
    io_write(16'h03c0, idx);
    io_write(16'h03c0, d);
  endtask : attr_write

  task automatic attr_read(input logic [7:0] idx, output logic [7:0] d);
    io_read(16'h03da, rd);
    io_write(16'h03c0, idx);
    io_read(16'h03c1, d);
  endtask : attr_read

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : pulse

  task automatic pixel(input logic [7:0] a, input logic [7:0] exp);
    pix_attr = a;
    pix_valid = 1'b1;
    @(negedge clk_sys);
    pix_valid = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk8("color word", exp, last_word);
  endtask : pixel

  // Hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= 5000) begin
      num_errors++;
      tally_and_finish;
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    attr_read(8'h14, rd);
    chk8("color set reset", 8'h00, rd);
    attr_write(8'h14, 8'h5a);
    attr_read(8'h14, rd);
    chk8("color set readback", 8'h0a, rd);
    io_read(16'h03c1, rd);
    chk8("data port keeps index", 8'h0a, rd);
    io_read(16'h03b0, rd);
    chk8("unmapped read", 8'hff, rd);
    io_write(16'h03c2, 8'h63);
    chk8("misc direct write", 8'h63, misc_output);
    io_read(16'h03cc, rd);
    chk8("misc readback", 8'h63, rd);
    $display("test registers done");
    attr_write(8'h03, 8'h15);
    attr_write(8'h10, 8'h00);
    pixel(8'h03, 8'h95);
    attr_write(8'h10, 8'h80);
    pixel(8'h03, 8'ha5);
    attr_write(8'h14, 8'h05);
    attr_write(8'h10, 8'h00);
    pixel(8'h03, 8'h55);
    attr_write(8'h10, 8'h40);
    pixel(8'he3, 8'he3);
    stall = 1'b1;
    repeat (2) @(negedge clk_sys);
    pix_attr = 8'h11;
    pix_valid = 1'b1;
    @(negedge clk_sys);
    pix_attr = 8'h22;
    @(negedge clk_sys);
    pix_valid = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk8("held valid", 8'h01, {7'h00, color_valid});
    stall = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk8("first after stall", 8'h11, prev_word);
    chk8("second after stall", 8'h22, last_word);
    chk32("words received", 32'h0000_0006, rx_count);
    $display("test color path done");
    // timing, start address, compare registers not programmed
    attr_write(8'h13, 8'h05);
    attr_write(8'h10, 8'h00);
    pulse(line_compare_hit);
    chk8("pan without compat", 8'h05, {4'h0, pan_out});
    attr_write(8'h10, 8'h20);
    pulse(line_compare_hit);
    chk8("pan forced zero", 8'h00, {4'h0, pan_out});
    pulse(vsync);
    chk8("pan restored", 8'h05, {4'h0, pan_out});
    io_write(16'h03c6, 8'h12);
    repeat (2) @(negedge clk_sys);
    chk8("charmap deferred", 8'h00, charmap_active);
    pulse(row_start);
    chk8("charmap at row", 8'h12, charmap_active);
    $display("test panning and charmap done");
    cursor_here = 1'b1;
    scan_row = 5'h06;
    cursor_start_reg = 5'h05;
    cursor_end_reg = 5'h03;
    repeat (2) @(negedge clk_sys);
    chk8("cursor inverted", 8'h00, {7'h00, cursor_on});
    cursor_start_reg = 5'h02;
    cursor_end_reg = 5'h06;
    repeat (2) @(negedge clk_sys);
    chk8("cursor shown", 8'h01, {7'h00, cursor_on});
    attr_write(8'h10, 8'h04);
    underline_row = 1'b1;
    char_last_col = 1'b1;
    // ninth column cases, codes around the line graphics range
    for (int i = 0; i < 6; i++) begin
      nine_dot = (i != 0);
      char_code = (i < 2) ? 8'h41 : (i == 2) ? 8'hc0 : (i == 3) ? 8'hdf : (i == 4) ? 8'he0 : 8'hbf;
      repeat (2) @(negedge clk_sys);
      chk8("underline", (i == 1 || i > 3) ? 8'h00 : 8'h01, {7'h00, underline_on});
    end
    $display("test cursor and underline done");
    mem_rdata = 32'h11223344;
    pulse(mem_rd);
    chk32("latch load", 32'h11223344, cpu_latch);
    mem_rdata = 32'h55667788;
    write_mode = 2'h1;
    pulse(mem_wr);
    chk32("latch write", 32'h11223344, mem_wdata);
    $display("test latches done");
    tally_and_finish;
  end
endmodule : attribute_color_output_tb
`default_nettype wire
